// [core/addr_break_map.vh]
// register map, field positions, encodings and reset values of the address break matcher
`ifndef ADDR_BREAK_MAP_VH
`define ADDR_BREAK_MAP_VH

// ****************************************
// register byte offsets
// ****************************************
`define ABM_OFS_CONTROL        12'h000
`define ABM_OFS_STATUS         12'h004
`define ABM_OFS_MATCH_ADDRESS  12'h008
`define ABM_OFS_MATCH_DATA     12'h00c

// ****************************************
// break_control fields
// ****************************************
`define ABM_CTL_RET_MASK_BIT   7
`define ABM_CTL_CYCLE_HI       6
`define ABM_CTL_CYCLE_LO       5
`define ABM_CTL_ACMP_HI        4
`define ABM_CTL_ACMP_LO        2
`define ABM_CTL_DCMP_HI        1
`define ABM_CTL_DCMP_LO        0
`define ABM_CTL_RESET          8'h80

// ****************************************
// break_status fields
// ****************************************
`define ABM_STS_FLAG_BIT       7
`define ABM_STS_ENABLE_BIT     6
`define ABM_STS_RSVD_ONES      6'h3f

// ****************************************
// match registers
// ****************************************
`define ABM_ADDR_RESET         16'hffff
`define ABM_DATA_RESET         16'h0000

// ****************************************
// cycle type encodings
// ****************************************
`define ABM_CYC_EXEC           2'h0
`define ABM_CYC_READ           2'h1
`define ABM_CYC_WRITE          2'h2
`define ABM_CYC_RDWR           2'h3

// ****************************************
// address compare encodings and masks
// ****************************************
`define ABM_ACMP_16            3'h0
`define ABM_ACMP_12            3'h1
`define ABM_ACMP_8             3'h2
`define ABM_ACMP_4             3'h3
`define ABM_AMASK_16           16'hffff
`define ABM_AMASK_12           16'hfff0
`define ABM_AMASK_8            16'hff00
`define ABM_AMASK_4            16'hf000
`define ABM_AMASK_NONE         16'h0000

// ****************************************
// data compare encodings
// ****************************************
`define ABM_DCMP_NONE          2'h0
`define ABM_DCMP_LOW           2'h1
`define ABM_DCMP_HIGH          2'h2
`define ABM_DCMP_WORD          2'h3

// ****************************************
// bus constants
// ****************************************
`define ABM_WORD_ZERO          32'h0000_0000
`define ABM_BYTE_ONES          8'hff

`endif

// [core/address_break_matcher.v]
// address break matcher: apb registers, cpu bus compare, break request
// Function
// RULE_01: return_mask_control 0 holds off interrupts one instruction after return; 1 none.
// RULE_02: cycle type field picks execution, data read, data write, or read/write.
// RULE_03: address compare field compares 16, upper 12, upper 8 or upper 4 bits.
// RULE_04: software never sets address compare field top bit; reserved encodings.
// RULE_05: data compare field: none, low byte, high byte, or full word.
// RULE_06: byte accesses take compare data from upper lane, even or odd address.
// RULE_07: word accesses: even address upper lane, odd address lower lane.
// RULE_08: word access to 8-bit register space counts as two upper-lane byte accesses.
// RULE_09: software puts byte-compare data in the high match data byte.
// RULE_10: break flag sets when address, data and control conditions all match.
// RULE_11: break flag clears only by writing 0 after reading it as 1.
// RULE_12: interrupt request whenever break flag and interrupt enable are both 1.
// RULE_13: break request ignores the cpu interrupt mask bit.
// RULE_14: exception handling starts only after the current instruction completes.
// RULE_15: status bits 5 to 0 always read as 1.
// RULE_16: match address register is read/write, resets to all ones.
// RULE_17: software loads the first byte address of the target instruction.
// RULE_18: match data register is read/write; reset content undefined.
// RULE_19: with data compare, address and data must match in the same cycle.
// RULE_20: break flag stays set until software clears it; more matches keep it.
`timescale 1ns/1ns
`include "addr_break_map.vh"

module address_break_matcher (
	input  wire        sys_clk_in,
	input  wire        rst_in,
	// apb slave
	input  wire        psel_in,
	input  wire        penable_in,
	input  wire        pwrite_in,
	input  wire [11:0] paddr_in,
	input  wire [31:0] pwdata_in,
	output reg  [31:0] prdata_out,
	output reg         pready_out,
	output reg         pslverr_out,
	// cpu internal bus, same clock
	input  wire        cpu_exec_in,
	input  wire        cpu_read_in,
	input  wire        cpu_write_in,
	input  wire        cpu_byte_in,
	input  wire        cpu_io8_in,
	input  wire [15:0] cpu_addr_in,
	input  wire [15:0] cpu_data_in,
	input  wire        cpu_insn_done_in,
	input  wire        cpu_return_in,
	// break request to cpu
	output reg         break_irq_out,
	output reg         break_take_out
);

	// ****************************************
	// registers
	// ****************************************
	reg  [7:0]  break_control;
	reg         break_flag;
	reg         break_interrupt_enable;
	reg  [15:0] match_address;
	reg  [15:0] match_data;
	reg         flag_read_armed;
	reg         return_hold;
	reg         take_pending;

	wire        return_mask_control;
	wire [1:0]  cycle_type_sel;
	wire [2:0]  addr_compare_sel;
	wire [1:0]  data_compare_sel;

	assign return_mask_control = break_control[`ABM_CTL_RET_MASK_BIT];
	assign cycle_type_sel      = break_control[`ABM_CTL_CYCLE_HI:`ABM_CTL_CYCLE_LO];
	assign addr_compare_sel    = break_control[`ABM_CTL_ACMP_HI:`ABM_CTL_ACMP_LO];
	assign data_compare_sel    = break_control[`ABM_CTL_DCMP_HI:`ABM_CTL_DCMP_LO];

	// ****************************************
	// apb decode
	// ****************************************
	wire        acc_phase;
	wire        acc_done;
	wire        wr_done;
	wire        rd_done;
	wire        rd_status;
	wire        sel_control;
	wire        sel_status;
	wire        sel_address;
	wire        sel_data;
	wire        sel_any;

	assign acc_phase   = psel_in & penable_in;
	assign acc_done    = acc_phase & pready_out;
	assign wr_done     = acc_done & pwrite_in;
	assign rd_done     = acc_done & ~pwrite_in;
	assign rd_status   = rd_done & sel_status;
	assign sel_control = paddr_in == `ABM_OFS_CONTROL;
	assign sel_status  = paddr_in == `ABM_OFS_STATUS;
	assign sel_address = paddr_in == `ABM_OFS_MATCH_ADDRESS;
	assign sel_data    = paddr_in == `ABM_OFS_MATCH_DATA;
	assign sel_any     = sel_control | sel_status | sel_address | sel_data;

	// ****************************************
	// apb response
	// ****************************************
	wire [7:0]  status_rdata;

	// reserved low bits are tied, not stored
	assign status_rdata = {break_flag, break_interrupt_enable, `ABM_STS_RSVD_ONES}; // RULE_15

	reg  [31:0] next_rdata;

	always @* begin
		next_rdata = `ABM_WORD_ZERO;
		case (1'b1)
			sel_control: begin
				next_rdata[7:0] = break_control;
			end
			sel_status: begin
				next_rdata[7:0] = status_rdata; // RULE_15
			end
			sel_address: begin
				next_rdata[15:0] = match_address;
			end
			sel_data: begin
				next_rdata[15:0] = match_data;
			end
			default: begin
				next_rdata = `ABM_WORD_ZERO;
			end
		endcase
	end

	// one wait state: answer is registered so outputs stay flop-driven
	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out  <= `ABM_WORD_ZERO;
		end else if (acc_phase & ~pready_out) begin
			pready_out  <= 1'b1;
			pslverr_out <= ~sel_any;
			prdata_out  <= pwrite_in ? `ABM_WORD_ZERO : next_rdata;
		end else begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out  <= `ABM_WORD_ZERO;
		end
	end

	// ****************************************
	// cpu bus compare
	// ****************************************
	reg  [15:0] addr_mask;
	wire        addr_hit;
	wire        acmp_reserved;

	// a zero mask would hit every address, so reserved settings are gated off
	assign acmp_reserved = addr_compare_sel[`ABM_CTL_ACMP_HI - `ABM_CTL_ACMP_LO];

	always @* begin
		case (addr_compare_sel)
			`ABM_ACMP_16: addr_mask = `ABM_AMASK_16; // RULE_03
			`ABM_ACMP_12: addr_mask = `ABM_AMASK_12; // RULE_03
			`ABM_ACMP_8:  addr_mask = `ABM_AMASK_8; // RULE_03
			`ABM_ACMP_4:  addr_mask = `ABM_AMASK_4; // RULE_03
			default:      addr_mask = `ABM_AMASK_NONE;
		endcase
	end

	// reserved settings are treated as never matching
	field_match #(.WIDTH(16)) u_addr_match (
		.value_in (cpu_addr_in),
		.ref_in   (match_address),
		.mask_in  (addr_mask),
		.hit_out  (addr_hit)
	);

	reg         cycle_hit;

	always @* begin
		case (cycle_type_sel)
			`ABM_CYC_EXEC:  cycle_hit = cpu_exec_in; // RULE_02
			`ABM_CYC_READ:  cycle_hit = cpu_read_in; // RULE_02
			`ABM_CYC_WRITE: cycle_hit = cpu_write_in; // RULE_02
			`ABM_CYC_RDWR:  cycle_hit = cpu_read_in | cpu_write_in; // RULE_02
			default:        cycle_hit = 1'b0;
		endcase
	end

	// lane carrying the transfer
	wire        byte_like;
	wire        upper_lane;
	wire        high_hit;
	wire        low_hit;

	assign byte_like  = cpu_byte_in | cpu_io8_in; // RULE_06 RULE_08
	assign upper_lane = byte_like | ~cpu_addr_in[0]; // RULE_07

	field_match #(.WIDTH(8)) u_high_match (
		.value_in (cpu_data_in[15:8]),
		.ref_in   (match_data[15:8]),
		.mask_in  (`ABM_BYTE_ONES),
		.hit_out  (high_hit)
	);

	field_match #(.WIDTH(8)) u_low_match (
		.value_in (cpu_data_in[7:0]),
		.ref_in   (match_data[7:0]),
		.mask_in  (`ABM_BYTE_ONES),
		.hit_out  (low_hit)
	);

	reg         data_hit;

	always @* begin
		case (data_compare_sel)
			`ABM_DCMP_NONE: data_hit = 1'b1; // RULE_05
			`ABM_DCMP_LOW:  data_hit = ~upper_lane & low_hit; // RULE_05 RULE_07
			`ABM_DCMP_HIGH: data_hit = upper_lane & high_hit; // RULE_05 RULE_06
			`ABM_DCMP_WORD: data_hit = ~byte_like & high_hit & low_hit; // RULE_05
			default:        data_hit = 1'b0;
		endcase
	end

	wire        match_event;

	// address and data judged on the same cycle
	assign match_event = cycle_hit & addr_hit & data_hit & ~acmp_reserved; // RULE_10 RULE_19

	// ****************************************
	// register writes
	// ****************************************
	wire        status_wr;
	wire        flag_clear;

	assign status_wr  = wr_done & sel_status;
	assign flag_clear = status_wr & flag_read_armed & ~pwdata_in[`ABM_STS_FLAG_BIT]; // RULE_11

	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			break_control          <= `ABM_CTL_RESET;
			break_interrupt_enable <= 1'b0;
			match_address          <= `ABM_ADDR_RESET; // RULE_16
			match_data             <= `ABM_DATA_RESET; // RULE_18
		end else if (wr_done) begin
			if (sel_control) begin
				break_control <= pwdata_in[7:0];
			end
			if (sel_status) begin
				break_interrupt_enable <= pwdata_in[`ABM_STS_ENABLE_BIT];
			end
			if (sel_address) begin
				match_address <= pwdata_in[15:0]; // RULE_16
			end
			if (sel_data) begin
				match_data <= pwdata_in[15:0]; // RULE_18
			end
		end
	end

	// ****************************************
	// break flag
	// ****************************************
	reg         next_break_flag;

	// a match in the clearing cycle wins over the clear
	always @* begin
		next_break_flag = break_flag;
		if (flag_clear) begin
			next_break_flag = 1'b0; // RULE_11
		end
		if (match_event) begin
			next_break_flag = 1'b1; // RULE_10 RULE_20
		end
	end

	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			break_flag <= 1'b0;
		end else begin
			break_flag <= next_break_flag;
		end
	end

	// arming: a status read that saw the flag at 1
	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			flag_read_armed <= 1'b0;
		end else if (rd_status & break_flag) begin
			flag_read_armed <= 1'b1; // RULE_11
		end else if (status_wr) begin
			flag_read_armed <= 1'b0; // RULE_11
		end
	end

	// ****************************************
	// request to cpu
	// ****************************************
	wire        next_break_irq;

	assign next_break_irq = break_flag & break_interrupt_enable; // RULE_12

	// interrupt mask bit of the cpu is deliberately not an input
	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			break_irq_out <= 1'b0;
		end else begin
			break_irq_out <= next_break_irq; // RULE_12 RULE_13
		end
	end

	// ****************************************
	// exception start
	// ****************************************

	// hold-off spans the one instruction after a return
	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			return_hold <= 1'b0;
		end else if (cpu_return_in) begin
			return_hold <= ~return_mask_control; // RULE_01
		end else if (cpu_insn_done_in) begin
			return_hold <= 1'b0; // RULE_01
		end
	end

	wire        take_now;

	assign take_now = break_irq_out & ~take_pending & cpu_insn_done_in
		& ~return_hold & ~cpu_return_in; // RULE_14 RULE_01

	// one take per raised request; rearms once the request drops
	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			take_pending   <= 1'b0;
			break_take_out <= 1'b0;
		end else begin
			break_take_out <= take_now; // RULE_14
			if (take_now) begin
				take_pending <= 1'b1;
			end else if (~break_irq_out) begin
				take_pending <= 1'b0;
			end
		end
	end

endmodule // address_break_matcher

// [core/field_match.v]
// masked equality comparator used for address and data lanes
`timescale 1ns/1ns

module field_match #(
	parameter WIDTH = 16
) (
	input  wire [WIDTH-1:0] value_in,
	input  wire [WIDTH-1:0] ref_in,
	input  wire [WIDTH-1:0] mask_in,
	output wire             hit_out
);

	// only bits under the mask take part
	assign hit_out = ((value_in ^ ref_in) & mask_in) == {WIDTH{1'b0}};

endmodule // field_match

// [verification/address_break_matcher_asserts.sv]
// port-level checks of the address break matcher
`timescale 1ns/1ns

module address_break_matcher_asserts (
	input wire        sys_clk_in,
	input wire        rst_in,
	input wire        psel_in,
	input wire        penable_in,
	input wire        pwrite_in,
	input wire [11:0] paddr_in,
	input wire [31:0] pwdata_in,
	input wire [31:0] prdata_out,
	input wire        pready_out,
	input wire        pslverr_out,
	input wire        cpu_exec_in,
	input wire        cpu_read_in,
	input wire        cpu_write_in,
	input wire        cpu_byte_in,
	input wire        cpu_io8_in,
	input wire [15:0] cpu_addr_in,
	input wire [15:0] cpu_data_in,
	input wire        cpu_insn_done_in,
	input wire        cpu_return_in,
	input wire        break_irq_out,
	input wire        break_take_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	sequence s_access;
		psel_in && $rose(penable_in);
	endsequence
	sequence s_taken;
		break_take_out ##1 break_irq_out [*2];
	endsequence

	a_ready_wait: assert property (s_access |=> pready_out)
		else $error("ready not one cycle after access");
	a_ready_pulse: assert property (pready_out |=> !pready_out)
		else $error("ready longer than one cycle");
	a_err_pair: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
		else $error("error without ready or with data");
	a_status_ones: assert property (pready_out && !pwrite_in && paddr_in == 12'h004
		|-> prdata_out[5:0] == 6'h3f)
		else $error("status reserved bits not ones");
	a_irq_cause: assert property ($rose(break_irq_out) |->
		$past(cpu_exec_in || cpu_read_in || cpu_write_in, 2)
		|| $past(pready_out && pwrite_in, 2))
		else $error("break request without cause");
	a_take_grant: assert property (break_take_out |->
		$past(cpu_insn_done_in && break_irq_out))
		else $error("exception start outside instruction end");
	a_take_pulse: assert property (break_take_out |=> !break_take_out)
		else $error("exception start longer than one cycle");
	a_take_once: assert property (s_taken |-> !break_take_out)
		else $error("second exception start for one request");
	a_return_hold: assert property (cpu_return_in |=> !break_take_out)
		else $error("exception start right after return");
	a_reset_idle: assert property ($fell(rst_in) |->
		!pready_out && !break_irq_out && !break_take_out)
		else $error("outputs active after reset");
endmodule // address_break_matcher_asserts

bind address_break_matcher address_break_matcher_asserts address_break_matcher_asserts_i (
	.sys_clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
	.prdata_out, .pready_out, .pslverr_out, .cpu_exec_in, .cpu_read_in, .cpu_write_in,
	.cpu_byte_in, .cpu_io8_in, .cpu_addr_in, .cpu_data_in, .cpu_insn_done_in,
	.cpu_return_in, .break_irq_out, .break_take_out);

// [verification/cpu_bus_model.sv]
// cpu core model driving the internal bus cycles seen by the matcher
`timescale 1ns/1ns

module cpu_bus_model (
	input  wire         clk_in,
	output logic [2:0]  kind_out,
	output logic        byte_out,
	output logic        io8_out,
	output logic [15:0] addr_out,
	output logic [15:0] data_out,
	output logic        done_out,
	output logic        ret_out
);
	initial {kind_out, byte_out, io8_out, addr_out, data_out, done_out, ret_out} = '0;

	// one cycle; kind is exec, read, write from msb down
	task cyc(input [2:0] k, input b, input w8, input [15:0] a, input [15:0] d);
		@(posedge clk_in);
		{kind_out, byte_out, io8_out, addr_out, data_out} <= {k, b, w8, a, d};
		@(posedge clk_in);
		// bus released: inverted so stale values never look like a match
		{kind_out, addr_out, data_out} <= {3'b000, ~a, ~d};
	endtask

	task ev(input r, input dn);
		@(posedge clk_in);
		{ret_out, done_out} <= {r, dn};
		@(posedge clk_in);
		{ret_out, done_out} <= 2'b00;
	endtask
endmodule // cpu_bus_model

// [verification/testbench.sv]
// self-checking bench of the address break matcher
`timescale 1ns/1ns
`include "addr_break_map.vh"

module testbench;
	logic        sys_clk_in, rst_in, psel_in, penable_in, pwrite_in, err;
	logic [11:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out, rd;
	logic        pready_out, pslverr_out, break_irq_out, break_take_out;
	logic [2:0]  kind;
	logic        cbyte, cio8, cdone, cret;
	logic [15:0] caddr, cdata;
	int          error_cnt = 0, tests_run = 0, cyc_cnt = 0;

	address_break_matcher address_break_matcher_i (.sys_clk_in, .rst_in, .psel_in,
		.penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
		.pslverr_out, .cpu_exec_in(kind[2]), .cpu_read_in(kind[1]), .cpu_write_in(kind[0]),
		.cpu_byte_in(cbyte), .cpu_io8_in(cio8), .cpu_addr_in(caddr), .cpu_data_in(cdata),
		.cpu_insn_done_in(cdone), .cpu_return_in(cret), .break_irq_out, .break_take_out);
	cpu_bus_model cpu_bus_model_i (.clk_in(sys_clk_in), .kind_out(kind), .byte_out(cbyte),
		.io8_out(cio8), .addr_out(caddr), .data_out(cdata), .done_out(cdone), .ret_out(cret));

	initial begin
		sys_clk_in = 0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end
	// generous ceiling: the whole run needs well under a thousand cycles
	always @(posedge sys_clk_in) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 5000) begin
			error_cnt++;
			end_sim();
		end
	end

	// ****************************************
	// helpers
	// ****************************************
	task end_sim;
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic c, input string m);
		tests_run++;
		if (c !== 1'b1) begin
			error_cnt++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk_in);
		{psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'b10, w, a, d};
		@(posedge sys_clk_in);
		penable_in <= 1'b1;
		do begin
			@(posedge sys_clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 20);
		{rd, err} = {prdata_out, pslverr_out};
		{psel_in, penable_in} <= 2'b00;
		chk(n < 20, "no ready");
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] e, input string m);
		apb(1'b0, a, 32'h0);
		chk(rd === e, m);
	endtask
	// one bus cycle, then flag read back and cleared by read-then-write-zero
	task hit(input [2:0] k, input b, input w8, input [15:0] a, input [15:0] d, input e);
		cpu_bus_model_i.cyc(k, b, w8, a, d);
		apb(1'b0, `ABM_OFS_STATUS, 32'h0);
		chk(rd[7] === e, "break flag");
		if (rd[7] === 1'b1)
			apb(1'b1, `ABM_OFS_STATUS, 32'h0);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task t_regs;
		rdc(`ABM_OFS_CONTROL, 32'h80, "control reset");
		rdc(`ABM_OFS_STATUS, 32'h3f, "status reset");
		rdc(`ABM_OFS_MATCH_ADDRESS, 32'hffff, "address reset");
		apb(1'b0, 12'h010, 32'h0);
		chk(err === 1'b1 && rd === 32'h0, "unmapped read");
		apb(1'b1, `ABM_OFS_MATCH_ADDRESS, 32'h1234);
		apb(1'b1, `ABM_OFS_MATCH_DATA, 32'h5a3c);
		rdc(`ABM_OFS_MATCH_ADDRESS, 32'h1234, "address rw");
		rdc(`ABM_OFS_MATCH_DATA, 32'h5a3c, "data rw");
	endtask
	task t_cycles;
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, `ABM_OFS_CONTROL, 32'h80 | (c << 5));
			for (int j = 0; j < 3; j++)
				hit(3'b100 >> j, 0, 0, 16'h1234, 0, (c == 0) ? j == 0 : (c == 3) ? j != 0 : c == j);
		end
	endtask
	task t_amask;
		for (int a = 0; a < 4; a++) begin
			apb(1'b1, `ABM_OFS_CONTROL, 32'ha0 | (a << 2));
			hit(3'b010, 0, 0, 16'h1234 ^ (16'h1 << (4 * a)), 0, 0);
			if (a > 0)
				hit(3'b010, 0, 0, 16'h1234 ^ (16'h1 << (4 * a - 1)), 0, 1);
		end
	endtask
	task t_lanes;
		logic [21:0] t [8] = '{{2'd2, 3'b101, 16'h5a00, 1'b1}, {2'd1, 3'b001, 16'h003c, 1'b1},
			{2'd1, 3'b000, 16'h003c, 1'b0}, {2'd2, 3'b000, 16'h5a00, 1'b1},
			{2'd2, 3'b011, 16'h5a00, 1'b1}, {2'd3, 3'b000, 16'h5a3c, 1'b1},
			{2'd3, 3'b000, 16'h5a3d, 1'b0}, {2'd0, 3'b001, 16'h0000, 1'b1}};
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, `ABM_OFS_CONTROL, 32'ha4 | t[i][21:20]);
			hit(3'b010, t[i][19], t[i][18], 16'h1230 | t[i][17], t[i][16:1], t[i][0]);
		end
	endtask
	task t_irq;
		apb(1'b1, `ABM_OFS_CONTROL, 32'h20);
		cpu_bus_model_i.cyc(3'b010, 0, 0, 16'h1234, 0);
		repeat (3) @(negedge sys_clk_in);
		chk(break_irq_out === 1'b0, "request while disabled");
		apb(1'b1, `ABM_OFS_STATUS, 32'hc0);
		apb(1'b1, `ABM_OFS_STATUS, 32'h40);
		cpu_bus_model_i.cyc(3'b010, 0, 0, 16'h1234, 0);
		repeat (2) @(negedge sys_clk_in);
		chk(break_irq_out === 1'b1, "flag lost");
		cpu_bus_model_i.ev(1, 0);
		cpu_bus_model_i.ev(0, 1);
		@(negedge sys_clk_in);
		chk(break_take_out === 1'b0, "start after return");
		cpu_bus_model_i.ev(0, 1);
		@(negedge sys_clk_in);
		chk(break_take_out === 1'b1, "no start");
		apb(1'b0, `ABM_OFS_STATUS, 32'h0);
		apb(1'b1, `ABM_OFS_STATUS, 32'h40);
		repeat (2) @(negedge sys_clk_in);
		chk(break_irq_out === 1'b0, "flag not cleared");
		apb(1'b1, `ABM_OFS_CONTROL, 32'ha0);
		cpu_bus_model_i.cyc(3'b010, 0, 0, 16'h1234, 0);
		cpu_bus_model_i.ev(1, 0);
		cpu_bus_model_i.ev(0, 1);
		@(negedge sys_clk_in);
		chk(break_take_out === 1'b1, "unmasked return held");
	endtask

	initial begin
		{rst_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = {4'b1000, 12'h0, 32'h0};
		repeat (2) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		t_regs();
		t_cycles();
		t_amask();
		t_lanes();
		t_irq();
		end_sim();
	end
endmodule // testbench
